// >>> rtl/adc_trim_coeff_map.vh
// Register indices, field positions and reset values of the trim coefficient bank
`ifndef ADC_TRIM_COEFF_MAP_VH
`define ADC_TRIM_COEFF_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_CH2_OFF_O2_LOW   8'h6a
`define IDX_CH2_OFF_O2_MID   8'h6b
`define IDX_CH2_OFF_O2_TOP   8'h6c
`define IDX_CH3_GAIN_O0_LOW  8'h6d
`define IDX_CH3_GAIN_O0_HIGH 8'h6e
`define IDX_CH3_GAIN_O1_MID  8'h6f
`define IDX_CH3_GAIN_O1_TOP  8'h70
`define IDX_CH3_GAIN_O2_MID  8'h71
`define IDX_CH3_GAIN_O3_LOW  8'h72
`define IDX_CH3_GAIN_O3_HIGH 8'h73
`define IDX_TRIM_CTRL        8'h80
`define IDX_TRIM_STATUS      8'h81

// ----------------------------------------------------------------
// Coefficient widths
// ----------------------------------------------------------------
`define OFF2_W  12
`define GAIN0_W 15
`define GAIN1_W 14
`define GAIN2_W 14
`define GAIN3_W 12

// ----------------------------------------------------------------
// Lowest coefficient bit held by each byte
// ----------------------------------------------------------------
`define POS_6A_OFF2  0
`define POS_6B_OFF2  2
`define POS_6C_OFF2  10
`define POS_6D_GAIN0 0
`define POS_6E_GAIN0 8
`define POS_6E_GAIN1 0
`define POS_6F_GAIN1 1
`define POS_70_GAIN1 9
`define POS_70_GAIN2 0
`define POS_71_GAIN2 3
`define POS_72_GAIN2 11
`define POS_72_GAIN3 0
`define POS_73_GAIN3 5

// ----------------------------------------------------------------
// Own control and status bits, reset values
// ----------------------------------------------------------------
`define CTRL_LOCK_BIT     0
`define STAT_LOADED_BIT   1'b0
`define STAT_ROWR_BIT     1
`define STAT_LOADED_POS   0
`define COEFF_RESET       1'b0
`define CTRL_RESET        1'b0

`endif

// >>> rtl/adc_trim_coeff_regs.v
// Read-only calibration coefficient bank on AHB-Lite
//
// How it works
// - 0x6B: offset order2 bits 9..2
// - 0x6C: offset order2 bits 11..10, rest zero
// - 0x6D: gain order0 bits 7..0
// - 0x6E: gain order1 bit0, gain order0 14..8
// - 0x6F: gain order1 bits 8..1
// - 0x70: gain order2 2..0, gain order1 13..9
// - 0x71: gain order2 bits 10..3
// - 0x72: gain order3 4..0, gain order2 13..11
// - 0x73: gain order3 11..5, bit7 zero
// - 0x6A top bits: offset order2 bits 1..0
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "adc_trim_coeff_map.vh"
module adc_trim_coeff_regs (
   // Clock and reset
   input  wire                 hclk,
   input  wire                 hresetn,
   // AHB-Lite slave
   input  wire                 hsel,
   input  wire [31:0]          haddr,
   input  wire [1:0]           htrans,
   input  wire                 hwrite,
   input  wire [2:0]           hsize,
   input  wire [31:0]          hwdata,
   input  wire                 hready,
   output wire                 hreadyout,
   output wire [1:0]           hresp,
   output reg  [31:0]          hrdata,
   // Factory trim load
   input  wire                 trim_load,
   input  wire [`OFF2_W-1:0]   trim_off2,
   input  wire [`GAIN0_W-1:0]  trim_gain0,
   input  wire [`GAIN1_W-1:0]  trim_gain1,
   input  wire [`GAIN2_W-1:0]  trim_gain2,
   input  wire [`GAIN3_W-1:0]  trim_gain3,
   // Coefficients to the converter
   output wire [`OFF2_W-1:0]   offset_coeff_order2,
   output wire [`GAIN0_W-1:0]  gain_coeff_order0,
   output wire [`GAIN1_W-1:0]  gain_coeff_order1,
   output wire [`GAIN2_W-1:0]  gain_coeff_order2,
   output wire [`GAIN3_W-1:0]  gain_coeff_order3,
   output wire                 trim_valid
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   // Bus front end
   wire                acc;
   wire                rd_acc;
   wire [7:0]          rd_idx;
   wire                hit;
   wire                wr_pend_r;
   wire [7:0]          wr_idx_r;
   wire                wr_hit_r;

   // Write decode and load qualification
   wire                wr_seen;
   wire                wr_in_bank;
   wire                load_ok;
   wire                wr_ctrl;
   wire                wr_stat;
   wire                wr_bank;

   // Own control and status registers
   reg                 lock_r;
   reg                 lock_nxt;
   reg                 loaded_r;
   reg                 loaded_nxt;
   reg                 rowr_r;
   reg                 rowr_nxt;
   wire                rowr_set;
   wire                rowr_clr;

   // Read path
   reg  [7:0]          byte_sel;
   reg  [31:0]         rd_nxt;

   // Byte images
   wire [7:0]          b6a;
   wire [7:0]          b6b;
   wire [7:0]          b6c;
   wire [7:0]          b6d;
   wire [7:0]          b6e;
   wire [7:0]          b6f;
   wire [7:0]          b70;
   wire [7:0]          b71;
   wire [7:0]          b72;
   wire [7:0]          b73;

   // ----------------------------------------------------------------
   // Bus front end
   // ----------------------------------------------------------------
   ahb_front u_front (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hready    (hready),
      .acc       (acc),
      .rd_acc    (rd_acc),
      .rd_idx    (rd_idx),
      .hit       (hit),
      .wr_pend_r (wr_pend_r),
      .wr_idx_r  (wr_idx_r),
      .wr_hit_r  (wr_hit_r),
      .hreadyout (hreadyout),
      .hresp     (hresp)
   );

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   assign wr_seen = wr_pend_r & wr_hit_r;
   assign wr_ctrl = wr_seen & (wr_idx_r == `IDX_TRIM_CTRL);
   assign wr_stat = wr_seen & (wr_idx_r == `IDX_TRIM_STATUS);

   // ----------------------------------------------------------------
   // Bank write detection, flagged but never stored
   // ----------------------------------------------------------------
   assign wr_in_bank = (wr_idx_r >= `IDX_CH2_OFF_O2_LOW) &
                       (wr_idx_r <= `IDX_CH3_GAIN_O3_HIGH);
   assign wr_bank    = wr_seen & wr_in_bank;

   // ----------------------------------------------------------------
   // Load qualification: the lock bit blocks factory loads
   // ----------------------------------------------------------------
   assign load_ok = trim_load & ~lock_r;

   // ----------------------------------------------------------------
   // Channel 2 offset coefficient
   // ----------------------------------------------------------------
   coeff_hold #(.W(`OFF2_W)) u_off2 (
      .hclk    (hclk),
      .hresetn (hresetn),
      .load    (load_ok),
      .din     (trim_off2),
      .q_r     (offset_coeff_order2)
   );

   // ----------------------------------------------------------------
   // Channel 3 gain coefficients, loaded only from the trim port
   // ----------------------------------------------------------------
   coeff_hold #(.W(`GAIN0_W)) u_gain0 (
      .hclk    (hclk),
      .hresetn (hresetn),
      .load    (load_ok),
      .din     (trim_gain0),
      .q_r     (gain_coeff_order0)
   );

   coeff_hold #(.W(`GAIN1_W)) u_gain1 (
      .hclk    (hclk),
      .hresetn (hresetn),
      .load    (load_ok),
      .din     (trim_gain1),
      .q_r     (gain_coeff_order1)
   );

   coeff_hold #(.W(`GAIN2_W)) u_gain2 (
      .hclk    (hclk),
      .hresetn (hresetn),
      .load    (load_ok),
      .din     (trim_gain2),
      .q_r     (gain_coeff_order2)
   );

   coeff_hold #(.W(`GAIN3_W)) u_gain3 (
      .hclk    (hclk),
      .hresetn (hresetn),
      .load    (load_ok),
      .din     (trim_gain3),
      .q_r     (gain_coeff_order3)
   );

   // ----------------------------------------------------------------
   // Channel 2 offset bytes
   // ----------------------------------------------------------------
   assign b6a = {offset_coeff_order2[`POS_6A_OFF2+1:`POS_6A_OFF2],
                 6'h00};
   assign b6b = offset_coeff_order2[`POS_6B_OFF2+7:`POS_6B_OFF2];
   assign b6c = {6'h00,
                 offset_coeff_order2[`POS_6C_OFF2+1:`POS_6C_OFF2]};

   // ----------------------------------------------------------------
   // Channel 3 gain bytes
   // ----------------------------------------------------------------
   assign b6d = gain_coeff_order0[`POS_6D_GAIN0+7:`POS_6D_GAIN0];
   assign b6e = {gain_coeff_order1[`POS_6E_GAIN1],
                 gain_coeff_order0[`POS_6E_GAIN0+6:`POS_6E_GAIN0]};
   assign b6f = gain_coeff_order1[`POS_6F_GAIN1+7:`POS_6F_GAIN1];
   assign b70 = {gain_coeff_order2[`POS_70_GAIN2+2:`POS_70_GAIN2],
                 gain_coeff_order1[`POS_70_GAIN1+4:`POS_70_GAIN1]};
   assign b71 = gain_coeff_order2[`POS_71_GAIN2+7:`POS_71_GAIN2];
   assign b72 = {gain_coeff_order3[`POS_72_GAIN3+4:`POS_72_GAIN3],
                 gain_coeff_order2[`POS_72_GAIN2+2:`POS_72_GAIN2]};
   assign b73 = {1'b0,
                 gain_coeff_order3[`POS_73_GAIN3+6:`POS_73_GAIN3]};

   // ----------------------------------------------------------------
   // Lock register
   // ----------------------------------------------------------------
   always @* begin
      lock_nxt = lock_r;
      if (wr_ctrl) begin
         lock_nxt = hwdata[`CTRL_LOCK_BIT];
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_r <= `CTRL_RESET;
      end else begin
         lock_r <= lock_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Loaded flag, sticky until reset
   // ----------------------------------------------------------------
   always @* begin
      loaded_nxt = loaded_r | load_ok;
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         loaded_r <= `STAT_LOADED_BIT;
      end else begin
         loaded_r <= loaded_nxt;
      end
   end

   assign trim_valid = loaded_r;

   // ----------------------------------------------------------------
   // Host write flag: set by a bank write, write 1 to clear
   // ----------------------------------------------------------------
   assign rowr_set = wr_bank;
   assign rowr_clr = wr_stat & hwdata[`STAT_ROWR_BIT];

   always @* begin
      rowr_nxt = rowr_r;
      if (rowr_clr) begin
         rowr_nxt = 1'b0;
      end
      // Set wins over the clear
      if (rowr_set) begin
         rowr_nxt = 1'b1;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rowr_r <= 1'b0;
      end else begin
         rowr_r <= rowr_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Bank byte select
   // ----------------------------------------------------------------
   always @* begin
      byte_sel = 8'h00;
      case (rd_idx)
         `IDX_CH2_OFF_O2_LOW: begin
            byte_sel = b6a;
         end
         `IDX_CH2_OFF_O2_MID: begin
            byte_sel = b6b;
         end
         `IDX_CH2_OFF_O2_TOP: begin
            byte_sel = b6c;
         end
         `IDX_CH3_GAIN_O0_LOW: begin
            byte_sel = b6d;
         end
         `IDX_CH3_GAIN_O0_HIGH: begin
            byte_sel = b6e;
         end
         `IDX_CH3_GAIN_O1_MID: begin
            byte_sel = b6f;
         end
         `IDX_CH3_GAIN_O1_TOP: begin
            byte_sel = b70;
         end
         `IDX_CH3_GAIN_O2_MID: begin
            byte_sel = b71;
         end
         `IDX_CH3_GAIN_O3_LOW: begin
            byte_sel = b72;
         end
         `IDX_CH3_GAIN_O3_HIGH: begin
            byte_sel = b73;
         end
         default: begin
            byte_sel = 8'h00;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Read-back word
   // ----------------------------------------------------------------
   // Own registers read their next state so a write just before is seen
   always @* begin
      rd_nxt = 32'h00000000;
      if (hit) begin
         case (rd_idx)
            `IDX_TRIM_CTRL: begin
               rd_nxt[`CTRL_LOCK_BIT] = lock_nxt;
            end
            `IDX_TRIM_STATUS: begin
               rd_nxt[`STAT_LOADED_POS] = loaded_nxt;
               rd_nxt[`STAT_ROWR_BIT]   = rowr_nxt;
            end
            default: begin
               rd_nxt[7:0] = byte_sel;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read data register
   // Captured in the address phase, held until the next read
   // ----------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (rd_acc) begin
         hrdata <= rd_nxt;
      end
   end

endmodule // adc_trim_coeff_regs

// >>> rtl/ahb_front.v
// AHB-Lite address phase capture, zero wait state
`timescale 1ns/1ps
module ahb_front (
   // Clock and reset
   input  wire       hclk,
   input  wire       hresetn,
   // Address phase
   input  wire       hsel,
   input  wire [31:0] haddr,
   input  wire [1:0] htrans,
   input  wire       hwrite,
   input  wire       hready,
   // Decoded access
   output wire       acc,
   output wire       rd_acc,
   output wire [7:0] rd_idx,
   output wire       hit,
   output reg        wr_pend_r,
   output reg  [7:0] wr_idx_r,
   output reg        wr_hit_r,
   // Response
   output wire       hreadyout,
   output wire [1:0] hresp
);

   assign acc       = hsel & htrans[1] & hready;
   assign rd_acc    = acc & ~hwrite;
   assign rd_idx    = haddr[9:2];
   assign hit       = (haddr[31:10] == 22'h000000);
   assign hreadyout = 1'b1;
   assign hresp     = 2'h0;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_idx_r  <= 8'h00;
         wr_hit_r  <= 1'b0;
      end else begin
         wr_pend_r <= acc & hwrite;
         wr_idx_r  <= rd_idx;
         wr_hit_r  <= hit;
      end
   end

endmodule // ahb_front

// >>> rtl/coeff_hold.v
// Holding register for one calibration coefficient
`timescale 1ns/1ps
`include "adc_trim_coeff_map.vh"
module coeff_hold #(
   parameter W = 12
) (
   // Clock and reset
   input  wire         hclk,
   input  wire         hresetn,
   // Load side
   input  wire         load,
   input  wire [W-1:0] din,
   // Stored value
   output reg  [W-1:0] q_r
);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q_r <= {W{`COEFF_RESET}};
      end else if (load) begin
         q_r <= din;
      end
   end

endmodule // coeff_hold

// >>> test/adc_trim_coeff_properties.sv
// Port checks of the trim coefficient bank
`timescale 1ns/1ps
module adc_trim_coeff_properties (
   // Clock, reset and bus
   input logic        hclk,
   input logic        hresetn,
   input logic        hsel,
   input logic [31:0] haddr,
   input logic [1:0]  htrans,
   input logic        hwrite,
   input logic        hready,
   input logic        hreadyout,
   input logic [1:0]  hresp,
   input logic [31:0] hrdata,
   // Trim side
   input logic        trim_load,
   input logic [11:0] trim_gain3,
   input logic [11:0] offset_coeff_order2,
   input logic [14:0] gain_coeff_order0,
   input logic [13:0] gain_coeff_order1,
   input logic [13:0] gain_coeff_order2,
   input logic [11:0] gain_coeff_order3,
   input logic        trim_valid
);
`include "trim_expect.svh"
   // ----
   // Helpers
   // ----
   wire       take  = hsel && htrans[1] && hready;
   wire       bank  = haddr[31:10] == 22'h0 && haddr[9:2] >= 8'h6a && haddr[9:2] <= 8'h73;
   wire       unmap = haddr[31:10] != 22'h0 || (haddr[9:2] > 8'h73 && haddr[9:2] < 8'h80);
   wire [7:0] exp_w = exp_byte(haddr[9:2], offset_coeff_order2, gain_coeff_order0, gain_coeff_order1,
                               gain_coeff_order2, gain_coeff_order3);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_rd_bank; take && !hwrite && bank; endsequence
   sequence s_wr_bank; take && hwrite && bank; endsequence
   // ----
   // Assertions
   // ----
   a_bus_okay: assert property (hreadyout && hresp == 2'h0) else $error("bus answer not ready OKAY");
   a_read_data:
      assert property (s_rd_bank |=> hrdata == {24'h0, $past(exp_w)}) else $error("bank read data wrong");
   a_write_ignored:
      assert property (s_wr_bank ##1 !trim_load |=> $stable({offset_coeff_order2, gain_coeff_order0,
         gain_coeff_order1, gain_coeff_order2, gain_coeff_order3})) else $error("bank write changed a coefficient");
   a_read_unmapped: assert property (take && !hwrite && unmap |=> hrdata == 32'h0) else $error("unmapped read");
   a_off2_hold:
      assert property (!$past(trim_load) |-> $stable(offset_coeff_order2)) else $error("offset changed");
   a_gain_hold:
      assert property (!$past(trim_load) |-> $stable({gain_coeff_order0, gain_coeff_order1,
         gain_coeff_order2, gain_coeff_order3})) else $error("gain changed without load");
   a_valid_sticky: assert property (trim_valid |=> trim_valid) else $error("valid dropped");
   a_valid_cause:
      assert property ($rose(trim_valid) |-> $past(trim_load) && gain_coeff_order3 == $past(trim_gain3))
      else $error("valid rose without load");
endmodule // adc_trim_coeff_properties

bind adc_trim_coeff_regs adc_trim_coeff_properties u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hready, .hreadyout, .hresp, .hrdata, .trim_load, .trim_gain3, .offset_coeff_order2, .gain_coeff_order0,
   .gain_coeff_order1, .gain_coeff_order2, .gain_coeff_order3, .trim_valid);

// >>> test/tb_top.sv
// Testbench of the trim coefficient bank
`timescale 1ns/1ps
module tb_top;
`include "trim_expect.svh"
   // ----
   // Signals
   // ----
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, trim_load = 0;
   logic [31:0] haddr = 0, hwdata = 0, rd;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   logic [11:0] t_o = 0, t_d = 0, m_o, m_d;
   logic [14:0] t_a = 0, m_a;
   logic [13:0] t_b = 0, t_c = 0, m_b, m_c;
   wire  [31:0] hrdata;
   wire  [1:0]  hresp;
   wire  [11:0] c_o, c_d;
   wire  [14:0] c_a;
   wire  [13:0] c_b, c_c;
   wire         hreadyout, vld;
   int          n_fail = 0, n_checks = 0;

   always #10 hclk = ~hclk;

   adc_trim_coeff_regs u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .trim_load, .trim_off2(t_o), .trim_gain0(t_a),
      .trim_gain1(t_b), .trim_gain2(t_c), .trim_gain3(t_d), .offset_coeff_order2(c_o),
      .gain_coeff_order0(c_a), .gain_coeff_order1(c_b), .gain_coeff_order2(c_c), .gain_coeff_order3(c_d),
      .trim_valid(vld));
   // ----
   // Tasks
   // ----
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input string nm, input logic [79:0] s, input logic [79:0] e);
      n_checks++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task wait_rdy;
      int k;
      k = 0;
      do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 20);
      if (hreadyout !== 1'b1) begin n_fail++; tally_and_finish; end
   endtask
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wait_rdy;
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
      chk("hresp", hresp, 2'h0);
   endtask
   task rd_bank(input string nm);
      for (int i = 8'h6a; i <= 8'h73; i++) begin
         ahb(0, {22'h0, i[7:0], 2'h0}, 0);
         chk(nm, rd, {24'h0, exp_byte(i[7:0], m_o, m_a, m_b, m_c, m_d)});
      end
   endtask
   task load(input logic [11:0] o, input logic [14:0] a, input logic [13:0] b, input logic [13:0] c,
      input logic [11:0] d, input logic take);
      {t_o, t_a, t_b, t_c, t_d} <= {o, a, b, c, d};
      trim_load <= 1;
      @(posedge hclk);
      trim_load <= 0;
      @(posedge hclk);
      if (take) {m_o, m_a, m_b, m_c, m_d} = {o, a, b, c, d};
      chk("coeffs", {c_o, c_a, c_b, c_c, c_d, vld}, {m_o, m_a, m_b, m_c, m_d, 1'h1});
   endtask
   task do_reset;
      hresetn <= 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1;
      {m_o, m_a, m_b, m_c, m_d} = 0;
      @(posedge hclk);
   endtask
   task t_reset;
      chk("rst_coeffs", {c_o, c_a, c_b, c_c, c_d, vld}, 0);
      chk("rst_hrdata", hrdata, 0);
      rd_bank("rst_bank");
      ahb(0, 32'h204, 0);
      chk("rst_status", rd, 0);
      $display("test reset done");
   endtask
   task t_map;
      load(12'h8a6, 15'h4d39, 14'h2c5b, 14'h1e27, 12'h6d3, 1);
      rd_bank("map_a");
      load(12'h759, 15'h32c6, 14'h13a4, 14'h21d8, 12'h92c, 1);
      rd_bank("map_b");
      $display("test map done");
   endtask
   task t_write;
      for (int i = 8'h6a; i <= 8'h73; i++) ahb(1, {22'h0, i[7:0], 2'h0}, 32'hffffffff);
      rd_bank("wr_bank");
      ahb(0, 32'h204, 0);
      chk("status_set", rd, 32'h3);
      ahb(1, 32'h204, 32'h2);
      ahb(0, 32'h204, 0);
      chk("status_clr", rd, 32'h1);
      $display("test write done");
   endtask
   task t_lock;
      ahb(1, 32'h200, 32'h1);
      ahb(0, 32'h200, 0);
      chk("lock", rd, 32'h1);
      load(12'hfff, 15'h7fff, 14'h3fff, 14'h3fff, 12'hfff, 0);
      rd_bank("lock_bank");
      ahb(1, 32'h200, 32'h0);
      load(12'hfff, 15'h7fff, 14'h3fff, 14'h3fff, 12'hfff, 1);
      rd_bank("full_bank");
      $display("test lock done");
   endtask
   task t_unmapped;
      ahb(1, 32'h1d0, 32'h5a);
      ahb(0, 32'h1d0, 0);
      chk("unmap", rd, 0);
      ahb(0, 32'h5ac, 0);
      chk("high_addr", rd, 0);
      ahb(0, 32'h204, 0);
      chk("status_end", rd, 32'h1);
      $display("test unmapped done");
   endtask
   // ----
   // Sequence
   // ----
   initial begin
      do_reset;
      t_reset;
      t_map;
      t_write;
      t_lock;
      t_unmapped;
      do_reset;
      t_reset;
      tally_and_finish;
   end
endmodule // tb_top

// >>> test/trim_expect.svh
// Expected register byte for a given set of coefficients
function automatic logic [7:0] exp_byte(input logic [7:0] i, input logic [11:0] o, input logic [14:0] a,
   input logic [13:0] b, input logic [13:0] c, input logic [11:0] d);
   case (i)
      8'h6a: exp_byte = {o[1:0], 6'h00};
      8'h6b: exp_byte = o[9:2];
      8'h6c: exp_byte = {6'h00, o[11:10]};
      8'h6d: exp_byte = a[7:0];
      8'h6e: exp_byte = {b[0], a[14:8]};
      8'h6f: exp_byte = b[8:1];
      8'h70: exp_byte = {c[2:0], b[13:9]};
      8'h71: exp_byte = c[10:3];
      8'h72: exp_byte = {d[4:0], c[13:11]};
      8'h73: exp_byte = {1'h0, d[11:5]};
      default: exp_byte = 8'h00;
   endcase
endfunction
